// ==== rtl/tac_regs.sv ====
// Alarm configuration, capability and limit registers of the thermal unit,
// with the alert pin logic. Assumes the serial engine presents one-cycle
// read and write strobes with a register pointer, and the converter gives
// the recorded temperature on i_temp in this clock domain.
`timescale 1ns/1ps
`include "tac_consts.svh"
// Overview of operation
// [R1] Reserved upper bits ignore writes, read zero
// [R2] Capability bit 7 reports shutdown alert behaviour
// [R3] Capability bit 6 reports bus timeout range
// [R4] Capability bits 4:3 report resolution code
// [R5] Capability bits 5,2,1,0 report fixed features
// [R6] Bits 10:9 select hysteresis amount
// [R7] Halt bit stops converter, cleared at reset
// [R8] Halt cannot be set while locked
// [R9] Critical lock freezes critical limit, sticky
// [R10] Alarm lock freezes high/low limits, sticky
// [R11] Locks freeze hysteresis, enable, polarity, mode
// [R12] Clear bit releases latched interrupt, reads zero
// [R13] No clear while above critical limit, except while halted
// [R14] Status bit mirrors asserted alert, gated by enable
// [R15] Clear works during halt; nothing sets status
// [R16] Disabled output released or driven low by polarity
// [R17] Critical-only mode; not settable under alarm lock
// [R18] Polarity and comparator/interrupt mode select
// [R19] Limits: sign bit 12, 0.25 degree LSB
// [R20] Limit bits 15:13 and 1:0 read zero
// [R21] All writable registers reset to zero
// [R22] Interrupt mode latches window crossings and critical rises; only critical rises in critical-only
// [R23] Comparator follows window; critical-only above critical
// [R24] Values compared as two's complement
// [R25] Blocked writes silently ignored
module tac_regs
  import tac_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [12:0] i_temp,
  output logic [15:0]      o_rdata,
  output logic             o_sensor_halt,
  output logic             o_alert_o,
  output logic             o_alert_oe
);

  // Control word state
  tac_hysteresis_select_t   hysteresis_select_ff;
  logic        halt_ff;
  logic        crit_lock_ff;
  logic        alarm_lock_ff;
  logic        out_en_ff;
  logic        crit_only_ff;
  logic        polarity_ff;
  logic        mode_ff;
  logic        status_ff;
  logic        latch_ff;
  logic        clr_pend_ff;
  logic [2:0]  prev_trip_ff;
  // Limit words
  logic [15:0] hi_lim_ff;
  logic [15:0] lo_lim_ff;
  logic [15:0] cr_lim_ff;
  // Output stage
  logic [15:0] rdata_ff;
  logic        alert_oe_ff;
  logic        alert_o_ff;

  tac_hysteresis_select_t   nxt_hysteresis_select;
  logic        nxt_halt;
  logic        nxt_crit_lock;
  logic        nxt_alarm_lock;
  logic        nxt_out_en;
  logic        nxt_crit_only;
  logic        nxt_polarity;
  logic        nxt_mode;
  logic        nxt_status;
  logic        nxt_latch;
  logic        nxt_clr_pend;
  logic [15:0] nxt_hi_lim;
  logic [15:0] nxt_lo_lim;
  logic [15:0] nxt_cr_lim;
  logic [15:0] nxt_rdata;
  logic        nxt_asserted;
  logic        nxt_alert_oe;

  logic        cfg_wr;
  logic        hi_wr;
  logic        lo_wr;
  logic        cr_wr;
  logic        locked;
  logic        clr_req;
  logic        run;
  logic        halt_start;
  logic [6:0]  hysteresis_select_amt;
  logic [2:0]  trip;
  logic        window_out;
  logic        crit_hit;
  logic        cond;
  logic        event_hit;
  logic        clr_now;
  logic [15:0] cfg_rd;
  logic [15:0] rd_mux;
  // Pointer decode and event wires
  logic [15:0] cap_word;
  logic        sel_cap;
  logic        sel_cfg;
  logic        sel_high;
  logic        sel_low;
  logic        sel_crit;
  logic        cfg_free;
  logic        halt_clears;
  logic        hi_cross;
  logic        lo_cross;
  logic        cr_rise;

  // Address decode
  assign sel_cap  = (i_addr == `TAC_ADDR_CAP);
  assign sel_cfg  = (i_addr == `TAC_ADDR_CFG);
  assign sel_high = (i_addr == `TAC_ADDR_HIGH);
  assign sel_low  = (i_addr == `TAC_ADDR_LOW);
  assign sel_crit = (i_addr == `TAC_ADDR_CRIT);
  assign cfg_wr   = i_wr_en && sel_cfg;
  assign hi_wr    = i_wr_en && sel_high;
  assign lo_wr    = i_wr_en && sel_low;
  assign cr_wr    = i_wr_en && sel_crit;

  assign locked  = crit_lock_ff | alarm_lock_ff;
  assign clr_req = cfg_wr & i_wdata[`TAC_CFG_CLEAR]; // R12
  assign run     = !halt_ff;
  assign cfg_free = cfg_wr && !locked;

  // Fixed capability word
  assign cap_word = `TAC_CAP_VALUE; // R2 R3 R4 R5

  // Frozen fields under either lock
  assign nxt_hysteresis_select = cfg_free ?
                    tac_hysteresis_select_t'(i_wdata[`TAC_CFG_HYSTERESIS_SELECT_HI:`TAC_CFG_HYSTERESIS_SELECT_LO]) :
                    hysteresis_select_ff; // R11 R6
  assign nxt_out_en   = cfg_free ? i_wdata[`TAC_CFG_OUT_EN] :
                        out_en_ff; // R11
  assign nxt_polarity = cfg_free ? i_wdata[`TAC_CFG_POLARITY] :
                        polarity_ff; // R11 R18
  assign nxt_mode     = cfg_free ? i_wdata[`TAC_CFG_MODE] :
                        mode_ff; // R11 R18

  // Halt may always be cleared, set only when unlocked
  assign nxt_halt = cfg_wr ? (i_wdata[`TAC_CFG_HALT] & (!locked | halt_ff)) :
                    halt_ff; // R8 R25
  assign halt_start = nxt_halt & !halt_ff;

  // Sticky locks, only reset clears them
  assign nxt_crit_lock  = crit_lock_ff |
                          (cfg_wr & i_wdata[`TAC_CFG_CRIT_LOCK]); // R9
  assign nxt_alarm_lock = alarm_lock_ff |
                          (cfg_wr & i_wdata[`TAC_CFG_ALRM_LOCK]); // R10

  // Critical-only may drop under alarm lock but not rise
  assign nxt_crit_only = cfg_wr ?
                         (i_wdata[`TAC_CFG_CRIT_ONLY] &
                          (!alarm_lock_ff | crit_only_ff)) :
                         crit_only_ff; // R17

  // Limit words keep only sign and ten magnitude bits
  assign nxt_hi_lim = (hi_wr && !alarm_lock_ff) ? (i_wdata & `TAC_LIM_MASK) :
                      hi_lim_ff; // R10 R19 R20 R25
  assign nxt_lo_lim = (lo_wr && !alarm_lock_ff) ? (i_wdata & `TAC_LIM_MASK) :
                      lo_lim_ff; // R10 R19 R20 R25
  assign nxt_cr_lim = (cr_wr && !crit_lock_ff) ? (i_wdata & `TAC_LIM_MASK) :
                      cr_lim_ff; // R9 R19 R20 R25

  // Hysteresis amount
  assign hysteresis_select_amt = (hysteresis_select_ff == TAC_HYSTERESIS_SELECT_A) ? `TAC_HYSTERESIS_SELECT_1P5 :
                    (hysteresis_select_ff == TAC_HYSTERESIS_SELECT_B) ? `TAC_HYSTERESIS_SELECT_3P0 :
                    (hysteresis_select_ff == TAC_HYSTERESIS_SELECT_C) ? `TAC_HYSTERESIS_SELECT_6P0 :
                                              `TAC_HYSTERESIS_SELECT_NONE; // R6

  // Three comparators: high, low, critical
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cmp
      logic [12:0]   lim_sel;
      tac_cmp_kind_t kind_sel;
      assign lim_sel  = (g == 0) ? hi_lim_ff[12:0] :
                        (g == 1) ? lo_lim_ff[12:0] : cr_lim_ff[12:0];
      assign kind_sel = (g == 0) ? TAC_CMP_HIGH :
                        (g == 1) ? TAC_CMP_LOW : TAC_CMP_CRIT;
      tac_limit_cmp u_cmp (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_run   (run),
        .i_kind  (kind_sel),
        .i_temp  (i_temp),
        .i_limit (lim_sel),
        .i_hysteresis_select  (hysteresis_select_amt),
        .o_trip  (trip[g])
      ); // R24
    end
  endgenerate

  assign window_out = trip[0] | trip[1];
  assign crit_hit   = trip[2];
  assign cond       = crit_only_ff ? crit_hit : (window_out | crit_hit); // R23 R17

  // Crossings in either direction of the alarm window, rise of critical
  assign hi_cross  = trip[0] ^ prev_trip_ff[0];
  assign lo_cross  = trip[1] ^ prev_trip_ff[1];
  assign cr_rise   = crit_hit & !prev_trip_ff[2];
  assign event_hit = run & (crit_only_ff ? cr_rise :
                            (hi_cross | lo_cross | cr_rise)); // R22 R17

  // Clear held off while running above critical, then executed
  assign clr_now = (clr_req | clr_pend_ff) & !crit_hit; // R13
  assign nxt_clr_pend = (!mode_ff || !run) ? 1'b0 :
                        (clr_req && crit_hit) ? 1'b1 :
                        !crit_hit ? 1'b0 : clr_pend_ff; // R13

  // Set wins over clear in the same cycle
  assign nxt_latch = !mode_ff ? 1'b0 :
                     !run ? (clr_req ? 1'b0 : latch_ff) :
                     event_hit ? 1'b1 :
                     clr_now ? 1'b0 : latch_ff; // R12 R22 R15

  // Capability bit 7 decides whether halting drops the status
  assign halt_clears = halt_start & cap_word[`TAC_CAP_SENSOR_HALT_BEH]; // R2

  assign nxt_status = halt_clears ? 1'b0 :
                      !run ? (clr_req ? 1'b0 : status_ff) :
                      mode_ff ? (nxt_latch | crit_hit) : cond; // R2 R15 R22 R23

  // Pin: disabled reads as deasserted, polarity picks released level
  assign nxt_asserted = nxt_status & nxt_out_en; // R14 R16
  assign nxt_alert_oe = nxt_polarity ? !nxt_asserted : nxt_asserted; // R16 R18

  // Read-back of the control word
  assign cfg_rd = {5'h00, hysteresis_select_ff, halt_ff, crit_lock_ff, alarm_lock_ff,
                   1'b0, status_ff & out_en_ff, out_en_ff, crit_only_ff,
                   polarity_ff, mode_ff}; // R1 R12 R14

  assign rd_mux = sel_cap  ? cap_word :
                  sel_cfg  ? cfg_rd :
                  sel_high ? hi_lim_ff :
                  sel_low  ? lo_lim_ff :
                  sel_crit ? cr_lim_ff :
                             `TAC_RD_NONE; // R1 R2 R3 R4 R5 R20
  assign nxt_rdata = i_rd_en ? rd_mux : rdata_ff;

  // Halt and sticky locks
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      halt_ff       <= 1'b0;
      crit_lock_ff  <= 1'b0;
      alarm_lock_ff <= 1'b0; // R21 R7
    end else begin
      halt_ff       <= nxt_halt; // R7
      crit_lock_ff  <= nxt_crit_lock;
      alarm_lock_ff <= nxt_alarm_lock;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hysteresis_select_ff      <= TAC_HYSTERESIS_SELECT_OFF;
      out_en_ff    <= 1'b0;
      crit_only_ff <= 1'b0;
      polarity_ff  <= 1'b0;
      mode_ff      <= 1'b0; // R21
    end else begin
      hysteresis_select_ff      <= nxt_hysteresis_select;
      out_en_ff    <= nxt_out_en;
      crit_only_ff <= nxt_crit_only;
      polarity_ff  <= nxt_polarity;
      mode_ff      <= nxt_mode;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_ff   <= 1'b0;
      latch_ff    <= 1'b0;
      clr_pend_ff <= 1'b0;
    end else begin
      status_ff   <= nxt_status;
      latch_ff    <= nxt_latch;
      clr_pend_ff <= nxt_clr_pend;
    end
  end

  // Last trips, for crossing detection
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_trip_ff <= 3'h0;
    end else begin
      prev_trip_ff <= trip;
    end
  end

  // Alarm limits
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hi_lim_ff <= `TAC_REG_RESET;
      lo_lim_ff <= `TAC_REG_RESET; // R21
    end else begin
      hi_lim_ff <= nxt_hi_lim;
      lo_lim_ff <= nxt_lo_lim;
    end
  end

  // Critical limit, on its own lock
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cr_lim_ff <= `TAC_REG_RESET; // R21
    end else begin
      cr_lim_ff <= nxt_cr_lim;
    end
  end

  // Read data holds between read strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= `TAC_RD_NONE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Pin drive registered so the pad never glitches
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      alert_oe_ff <= 1'b0;
      alert_o_ff  <= 1'b0;
    end else begin
      alert_oe_ff <= nxt_alert_oe;
      alert_o_ff  <= 1'b0;
    end
  end

  assign o_rdata       = rdata_ff;
  assign o_sensor_halt = halt_ff; // R7
  assign o_alert_o     = alert_o_ff;
  assign o_alert_oe    = alert_oe_ff;

endmodule // tac_regs

// ==== rtl/tac_consts.svh ====
// Constants of the thermal alarm register block: addresses, fields, values.
// Assumes inclusion by bare name from the two design modules.
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH

// Register pointer values
`define TAC_ADDR_CAP      3'h0
`define TAC_ADDR_CFG      3'h1
`define TAC_ADDR_HIGH     3'h2
`define TAC_ADDR_LOW      3'h3
`define TAC_ADDR_CRIT     3'h4

// Fixed capability word
`define TAC_CAP_VALUE     16'h007f
`define TAC_CAP_SENSOR_HALT_BEH  7

// Control word fields
`define TAC_CFG_HYSTERESIS_SELECT_HI   10
`define TAC_CFG_HYSTERESIS_SELECT_LO   9
`define TAC_CFG_HALT      8
`define TAC_CFG_CRIT_LOCK 7
`define TAC_CFG_ALRM_LOCK 6
`define TAC_CFG_CLEAR     5
`define TAC_CFG_STATUS    4
`define TAC_CFG_OUT_EN    3
`define TAC_CFG_CRIT_ONLY 2
`define TAC_CFG_POLARITY  1
`define TAC_CFG_MODE      0

// Limit word layout and reset values
`define TAC_LIM_MASK      16'h1ffc
`define TAC_LIM_SIGN      12
`define TAC_REG_RESET     16'h0000
`define TAC_RD_NONE       16'h0000

// Hysteresis in 0.0625 degree steps
`define TAC_HYSTERESIS_SELECT_NONE     7'h00
`define TAC_HYSTERESIS_SELECT_1P5      7'h18
`define TAC_HYSTERESIS_SELECT_3P0      7'h30
`define TAC_HYSTERESIS_SELECT_6P0      7'h60

`endif

// ==== rtl/tac_pkg.sv ====
// Types shared by the thermal alarm register block.
// Assumes tac_consts.svh is on the include path.
package tac_pkg;

  typedef enum logic [1:0] {
    TAC_HYSTERESIS_SELECT_OFF = 2'b00,
    TAC_HYSTERESIS_SELECT_A   = 2'b01,
    TAC_HYSTERESIS_SELECT_B   = 2'b10,
    TAC_HYSTERESIS_SELECT_C   = 2'b11
  } tac_hysteresis_select_t;

  typedef enum logic [1:0] {
    TAC_CMP_HIGH = 2'b00,
    TAC_CMP_LOW  = 2'b01,
    TAC_CMP_CRIT = 2'b10
  } tac_cmp_kind_t;

endpackage

// ==== rtl/tac_limit_cmp.sv ====
// One limit comparator with hysteresis, holding its trip state.
// Assumes temperature and limit share the 13-bit two's complement scale.
`timescale 1ns/1ps
`include "tac_consts.svh"
module tac_limit_cmp
  import tac_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic          i_run,
  input  wire tac_cmp_kind_t i_kind,
  input  wire logic [12:0]   i_temp,
  input  wire logic [12:0]   i_limit,
  input  wire logic [6:0]    i_hysteresis_select,
  output logic               o_trip
);

  logic               trip_ff;
  logic               nxt_trip;
  logic signed [13:0] temp_w;
  logic signed [13:0] lim_w;
  logic signed [13:0] hysteresis_select_w;
  logic signed [13:0] lim_dn;
  logic signed [13:0] lim_up;
  logic               set_w;
  logic               rel_w;

  // Sign extension keeps the compare two's complement
  assign temp_w = $signed({i_temp[`TAC_LIM_SIGN], i_temp});
  assign lim_w  = $signed({i_limit[`TAC_LIM_SIGN], i_limit});
  assign hysteresis_select_w = $signed({7'h00, i_hysteresis_select});
  assign lim_dn = lim_w - hysteresis_select_w;
  assign lim_up = lim_w + hysteresis_select_w;

  assign set_w = (i_kind == TAC_CMP_HIGH) ? (temp_w >  lim_w)  :
                 (i_kind == TAC_CMP_LOW)  ? (temp_w <  lim_w)  :
                                            (temp_w >= lim_w);
  assign rel_w = (i_kind == TAC_CMP_HIGH) ? (temp_w <= lim_dn) :
                 (i_kind == TAC_CMP_LOW)  ? (temp_w >= lim_up) :
                                            (temp_w <  lim_dn);
  // Frozen while halted so nothing new trips
  assign nxt_trip = !i_run ? trip_ff : (trip_ff ? !rel_w : set_w);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trip_ff <= 1'b0;
    end else begin
      trip_ff <= nxt_trip;
    end
  end

  assign o_trip = trip_ff;

endmodule // tac_limit_cmp

// ==== tb/tac_regs_properties.sv ====
// Port checker of the thermal alarm register block.
// Assumes binding to tac_regs; a helper remembers whether a lock was written.
`timescale 1ns/1ps
module tac_regs_props (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic [12:0] i_temp,
  input  wire logic [15:0] o_rdata,
  input  wire logic        o_sensor_halt,
  input  wire logic        o_alert_o,
  input  wire logic        o_alert_oe
);
  logic lk_ff;
  logic nxt_lk;
  wire  cfg_wr;
  assign cfg_wr = i_wr_en && i_addr == 3'h1;
  assign nxt_lk = lk_ff | (cfg_wr & (i_wdata[7] | i_wdata[6]));
  always_ff @(posedge i_clk) lk_ff <= i_rst ? 1'b0 : nxt_lk;
  default clocking cb @(posedge i_clk); endclocking
  sequence s_rd(a);
    i_rd_en && i_addr == a;
  endsequence
  sequence s_cfg_free;
    cfg_wr && !lk_ff;
  endsequence
  a_reset_clears: assert property (i_rst |=>
    o_rdata == 16'h0000 && !o_sensor_halt && !o_alert_oe) else $error("reset state wrong");
  a_pin_value: assert property (disable iff (i_rst) o_alert_o == 1'b0)
    else $error("alert pin value not 0");
  a_cap_fixed: assert property (disable iff (i_rst) s_rd(3'h0) |=> o_rdata == 16'h007f)
    else $error("capability word wrong");
  a_unmapped_zero: assert property (disable iff (i_rst)
    i_rd_en && i_addr > 3'h4 |=> o_rdata == 16'h0000) else $error("unmapped read not 0");
  a_cfg_reserved: assert property (disable iff (i_rst) s_rd(3'h1) |=>
    o_rdata[15:11] == 5'h00 && !o_rdata[5]) else $error("control word reserved bits set");
  a_limit_mask: assert property (disable iff (i_rst) i_rd_en && i_addr inside {[3'h2:3'h4]}
    |=> (o_rdata & 16'he003) == 16'h0000) else $error("limit unused bits set");
  a_rdata_hold: assert property (disable iff (i_rst) !i_rd_en |=> $stable(o_rdata))
    else $error("read data moved without read");
  a_halt_locked: assert property (disable iff (i_rst)
    cfg_wr && lk_ff && !o_sensor_halt |=> !o_sensor_halt) else $error("halt set under lock");
  a_halt_clear: assert property (disable iff (i_rst) cfg_wr && !i_wdata[8] |=> !o_sensor_halt)
    else $error("halt not cleared");
  a_halt_set: assert property (disable iff (i_rst) s_cfg_free ##0 i_wdata[8] |=> o_sensor_halt)
    else $error("halt not set");
  a_off_pin: assert property (disable iff (i_rst) s_cfg_free ##0 !i_wdata[3]
    |=> o_alert_oe == $past(i_wdata[1])) else $error("disabled pin level wrong");
endmodule // tac_regs_props

bind tac_regs tac_regs_props chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_temp(i_temp),
  .o_rdata(o_rdata), .o_sensor_halt(o_sensor_halt), .o_alert_o(o_alert_o),
  .o_alert_oe(o_alert_oe));

// ==== tb/tac_host.sv ====
// Host-side model: serial engine register strobes and the pin pull-up.
// Assumes the block's clock; requests change at falling edges only.
`timescale 1ns/1ps
module tac_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_alert_oe,
  output logic             o_wr_en,
  output logic             o_rd_en,
  output logic [2:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_pin
);
  // Pull-up wins when nobody pulls low
  assign o_pin = i_alert_oe ? 1'b0 : 1'b1;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 3'h0;
    o_wdata = 16'h0000;
  end
  // Idle bus shows inverted data, never the last value
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d = i_rdata;
  endtask
endmodule // tac_host

// ==== tb/test_thermal_alarm_config_regs.sv ====
// Self-checking bench of the thermal alarm register block.
// Assumes tac_host drives the strobes and the bound port checker.
`timescale 1ns/1ps
module test_thermal_alarm_config_regs;
  logic        clk;
  logic        rst;
  logic [12:0] temp;
  logic        wr_en;
  logic        rd_en;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        halt;
  logic        alert_o;
  logic        alert_oe;
  logic        pin;
  logic [15:0] rv;
  logic [15:0] w;
  int          err_count;
  int          comparisons;

  tac_regs dut_u (.i_clk(clk), .i_rst(rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .i_temp(temp), .o_rdata(rdata),
    .o_sensor_halt(halt), .o_alert_o(alert_o), .o_alert_oe(alert_oe));
  tac_host host_u (.i_clk(clk), .i_rdata(rdata), .i_alert_oe(alert_oe), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic oe_exp(input logic asrt, input logic en, input logic pol);
    return en ? asrt ^ pol : pol;
  endfunction
  function automatic logic [12:0] hysteresis_select_lsb(input int k);
    return k == 0 ? 13'h0000 : 13'(12 << k);
  endfunction

  task automatic check_word(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] e);
    host_u.rd(a, rv);
    check_word("rdata", e, rv);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic temp_pin(input logic [12:0] t, input logic e);
    temp = t;
    cyc(4);
    check_bit("alert_oe", e, alert_oe);
    check_bit("pin", !e, pin);
  endtask
  task automatic sweep;
    for (int a = 0; a < 8; a++) rchk(3'(a), a == 0 ? 16'h007f : 16'h0000);
    check_bit("alert_oe", 1'b0, alert_oe);
    check_bit("alert_o", 1'b0, alert_o);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    temp = 13'h0000;
    w = $urandom(95884);
    cyc(2);
    rst = 1'b0;
    sweep();
    $display("reset done");
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      host_u.wr(3'(2 + i % 3), w);
      rchk(3'(2 + i % 3), w & 16'h1ffc);
      host_u.wr(3'(5 + i % 3), w);
      rchk(3'(5 + i % 3), 16'h0000);
      w = w & 16'hff37;
      host_u.wr(3'h1, w);
      rchk(3'h1, w & 16'h0707);
      check_bit("alert_oe", oe_exp(1'b0, 1'b0, w[1]), alert_oe);
    end
    $display("random words done");
    host_u.wr(3'h1, 16'h0008);
    host_u.wr(3'h2, 16'h0190);
    host_u.wr(3'h3, 16'h1ce0);
    host_u.wr(3'h4, 16'h07d0);
    temp_pin(13'h0000, 1'b0);
    for (int k = 0; k < 4; k++) begin
      host_u.wr(3'h1, 16'h0008 | 16'(k << 9));
      temp_pin(13'h0191, 1'b1);
      temp_pin(13'h0191 - hysteresis_select_lsb(k), 1'b1);
      temp_pin(13'h0190 - hysteresis_select_lsb(k), 1'b0);
      rchk(3'h1, 16'h0008 | 16'(k << 9));
    end
    $display("hysteresis done");
    host_u.wr(3'h1, 16'h0008);
    temp_pin(13'h0191, 1'b1);
    rchk(3'h1, 16'h0018);
    host_u.wr(3'h1, 16'h0028);
    temp_pin(13'h0191, 1'b1);
    host_u.wr(3'h1, 16'h000a);
    temp_pin(13'h0191, oe_exp(1'b1, 1'b1, 1'b1));
    host_u.wr(3'h1, 16'h000c);
    temp_pin(13'h0191, 1'b0);
    temp_pin(13'h07d0, 1'b1);
    temp_pin(13'h0000, 1'b0);
    $display("comparator done");
    host_u.wr(3'h1, 16'h0009);
    temp_pin(13'h0191, 1'b1);
    host_u.wr(3'h1, 16'h0029);
    temp_pin(13'h0191, 1'b0);
    temp_pin(13'h0000, 1'b1);
    host_u.wr(3'h1, 16'h0029);
    temp_pin(13'h07d0, 1'b1);
    host_u.wr(3'h1, 16'h0029);
    temp_pin(13'h07d0, 1'b1);
    temp_pin(13'h0191, 1'b0);
    host_u.wr(3'h1, 16'h002d);
    temp_pin(13'h0000, 1'b0);
    temp_pin(13'h07d0, 1'b1);
    host_u.wr(3'h1, 16'h002d);
    temp_pin(13'h0000, 1'b0);
    $display("interrupt done");
    host_u.wr(3'h1, 16'h0008);
    temp_pin(13'h0191, 1'b1);
    host_u.wr(3'h1, 16'h0108);
    check_bit("halt", 1'b1, halt);
    temp_pin(13'h0000, 1'b1);
    host_u.wr(3'h1, 16'h0128);
    temp_pin(13'h0000, 1'b0);
    temp_pin(13'h0191, 1'b0);
    host_u.wr(3'h1, 16'h0008);
    check_bit("halt", 1'b0, halt);
    temp_pin(13'h0000, 1'b0);
    $display("halt done");
    host_u.wr(3'h1, 16'h01c8);
    rchk(3'h1, 16'h01c8);
    host_u.wr(3'h1, 16'h00c8);
    check_bit("halt", 1'b0, halt);
    host_u.wr(3'h1, 16'h0707);
    rchk(3'h1, 16'h00c8);
    host_u.wr(3'h1, 16'h0000);
    rchk(3'h1, 16'h00c8);
    for (int a = 2; a < 5; a++) host_u.wr(3'(a), 16'h0aa8);
    rchk(3'h2, 16'h0190);
    rchk(3'h3, 16'h1ce0);
    rchk(3'h4, 16'h07d0);
    $display("locks done");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    sweep();
    $display("second reset done");
    give_verdict();
  end
endmodule // test_thermal_alarm_config_regs
